// >>> cfa_pkg.sv
// Package: constants for the CAN flow control and addressing helper
package cfa_pkg;
    localparam int DATA_BYTES = 8;
    localparam logic [7:0] PCI_FIRST = 8'h10;
    localparam logic [7:0] PCI_FLOW = 8'h30;
    localparam logic [3:0] PCI_SINGLE_NIB = 4'h0;
    localparam logic [3:0] PCI_FIRST_NIB = 4'h1;
    localparam logic [3:0] PCI_CONSEC_NIB = 4'h2;
    localparam logic [3:0] PCI_FLOW_NIB = 4'h3;
    localparam logic [7:0] RX_EXT_ADDR_RST = 8'hf1;
    localparam logic [7:0] FREQ_MATCH_RST = 8'hff;
    localparam logic [3:0] FC_MODE_AUTO = 4'h0;
    localparam logic [3:0] FC_MODE_USER = 4'h1;
    localparam logic [3:0] FC_MODE_DATA = 4'h2;
    localparam logic [3:0] FC_MODE_AUTO_ALL = 4'h8;
    localparam logic [3:0] FC_MODE_USER_ALL = 4'h9;
    localparam logic [3:0] FC_MODE_DATA_ALL = 4'ha;
    localparam logic [28:0] STD_FC_ID = 29'h000007e0;
    localparam logic [63:0] STD_FC_DATA = 64'h3000000000000000;
    localparam logic [28:0] STD_ID_OFFSET = 29'h00000008;
    localparam int FP_MATCH_BIT = 0;
    localparam int FP_NOSIG_BIT = 1;
    localparam int FP_BLOCK_STD_BIT = 2;
endpackage

// >>> cfa_rate_meter.sv
// Measures the CAN input edge rate over a fixed window
`timescale 1ns/1ps
`default_nettype none
module cfa_rate_meter #(
    parameter int WIN_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic rx_i,
    input wire logic [WIN_W-1:0] window_i,
    output logic [WIN_W-1:0] edges_o,
    output logic done_o
);
    initial begin
        if (WIN_W < 4) $error("WIN_W too small");
    end
    typedef struct packed {
        logic [2:0] sync;
        logic [WIN_W-1:0] tick;
        logic [WIN_W-1:0] cnt;
        logic [WIN_W-1:0] edges;
        logic done;
    } cfa_meter_type;
    cfa_meter_type st_q, st_d;
    // ------
    // Three-stage sync; edge counted when 2nd and 3rd stages differ
    // ------
    always_comb begin
        st_d = st_q;
        st_d.sync = {st_q.sync[1:0], rx_i};
        st_d.done = 1'b0;
        if (!enable_i) begin
            st_d.tick = '0;
            st_d.cnt = '0;
        end else begin
            if (st_q.sync[2] != st_q.sync[1]) begin
                st_d.cnt = st_q.cnt + 1'b1;
            end
            if (st_q.tick == window_i) begin
                st_d.tick = '0;
                st_d.edges = st_d.cnt;
                st_d.cnt = '0;
                st_d.done = 1'b1;
            end else begin
                st_d.tick = st_q.tick + 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign edges_o = st_q.edges;
    assign done_o = st_q.done;
endmodule
`default_nettype wire

// >>> cfa_frame_class.sv
// Classifies a transport frame by its protocol control byte
`timescale 1ns/1ps
`default_nettype none
module cfa_frame_class
    import cfa_pkg::*;
(
    input wire logic [7:0] pci_i,
    output logic is_first_o,
    output logic is_flow_o,
    output logic is_single_o,
    output logic is_consec_o
);
    always_comb begin
        is_first_o = (pci_i[7:4] == PCI_FIRST_NIB);
        is_flow_o = (pci_i[7:4] == PCI_FLOW_NIB);
        is_single_o = (pci_i[7:4] == PCI_SINGLE_NIB);
        is_consec_o = (pci_i[7:4] == PCI_CONSEC_NIB);
    end
endmodule
`default_nettype wire

// >>> cfa_flow_ctrl.sv
// Flow control reply, extended addressing and send gate for CAN transport
// Functional notes
// RULE_01 - At most eight data bytes per frame
// RULE_02 - Sender waits for flow control after first frame
// RULE_03 - Auto option on: reply to first frames
// RULE_04 - Mode 0: standard identifier and data
// RULE_05 - Mode 1 refused unless identifier, data defined
// RULE_06 - Mode 1: user identifier, 11 or 29 bit
// RULE_07 - Mode 2: user data, received identifier copied
// RULE_08 - Mode 0 restores standard replies immediately
// RULE_09 - Modes 8,9,A reply after every message; code replies to single, first and consecutive frames only
// RULE_10 - Extended addressing: byte 0 is target address
// RULE_11 - Host payload gets identifier, address, control bytes
// RULE_12 - Receive extended address resets to f1
// RULE_13 - Control byte nibble classifies frame type
// RULE_14 - Search send needs rate match or silence
// RULE_15 - Nonstandard rate blocked if standard rate seen
// RULE_16 - Match parameter resets all ones, writable anytime
// RULE_17 - Frequency check only during protocol search
// RULE_18 - Bypass initiation skips frequency check
// RULE_19 - Host should check status after bypass
// RULE_20 - Auto option off: no flow control sent
`timescale 1ns/1ps
`default_nettype none
module cfa_flow_ctrl
    import cfa_pkg::*;
#(
    parameter int WIN_W = 16,
    parameter logic [15:0] RATE_WINDOW = 16'd1000,
    parameter logic [15:0] EDGES_250 = 16'd100,
    parameter logic [15:0] EDGES_500 = 16'd200,
    parameter logic [15:0] EDGE_TOL = 16'd30,
    parameter logic [15:0] EDGES_SILENT = 16'd2
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic flow_control_auto_enable_i,
    input wire logic flow_control_mode_select_i,
    input wire logic [3:0] flow_control_mode_i,
    input wire logic flow_control_header_define_i,
    input wire logic [28:0] flow_control_header_i,
    input wire logic flow_control_header_ext_i,
    input wire logic flow_control_data_define_i,
    input wire logic [63:0] flow_control_data_i,
    input wire logic [3:0] flow_control_data_len_i,
    input wire logic transmit_extended_address_set_i,
    input wire logic receive_extended_address_set_i,
    input wire logic [7:0] extended_address_i,
    input wire logic ext_addr_enable_i,
    input wire logic transmit_header_set_i,
    input wire logic [28:0] transmit_header_i,
    input wire logic transmit_header_ext_i,
    input wire logic frequency_match_parameter_set_i,
    input wire logic [7:0] frequency_match_parameter_i,
    input wire logic searching_i,
    input wire logic rate_is_500_i,
    input wire logic rate_is_standard_i,
    input wire logic bypass_initiation_i,
    input wire logic can_rx_i,
    input wire logic rx_valid_i,
    input wire logic [28:0] rx_id_i,
    input wire logic rx_id_ext_i,
    input wire logic [63:0] rx_data_i,
    input wire logic host_valid_i,
    input wire logic [55:0] host_data_i,
    input wire logic [3:0] host_len_i,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [28:0] tx_id_o,
    output logic tx_id_ext_o,
    output logic [63:0] tx_data_o,
    output logic [3:0] tx_len_o,
    output logic host_ready_o,
    output logic mode_error_o,
    output logic mode_ok_o,
    output logic [3:0] flow_control_mode_o,
    output logic rx_accept_o,
    output logic send_allowed_o,
    output logic [7:0] frequency_match_o
);
    initial begin
        if (WIN_W < 16) $error("WIN_W must cover RATE_WINDOW");
    end
    typedef struct packed {
        logic [3:0] mode;
        logic hdr_def;
        logic dat_def;
        logic [28:0] fc_id;
        logic fc_ext;
        logic [63:0] fc_data;
        logic [3:0] fc_len;
        logic [7:0] tx_ea;
        logic [7:0] rx_ea;
        logic [28:0] tx_hdr;
        logic tx_hdr_ext;
        logic [7:0] fmatch;
        logic allow;
        logic tx_valid;
        logic [28:0] tx_id;
        logic tx_ext;
        logic [63:0] tx_data;
        logic [3:0] tx_len;
        logic host_rdy;
        logic err;
        logic ok;
        logic accept;
    } cfa_state_type;

    cfa_state_type st_q, st_d;
    logic [WIN_W-1:0] edges;
    logic meas_done;
    logic is_first;
    logic is_flow;
    logic is_single;
    logic is_consec;
    logic [7:0] pci;
    logic [7:0] addr_byte;

    // ------
    // Submodules
    // ------
    cfa_rate_meter #(
        .WIN_W(WIN_W)
    ) u_meter (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .enable_i(searching_i && !bypass_initiation_i), // RULE_17 RULE_18
        .rx_i(can_rx_i),
        .window_i(WIN_W'(RATE_WINDOW)),
        .edges_o(edges),
        .done_o(meas_done)
    );

    // PCI sits after the address byte when extended addressing is on
    assign addr_byte = rx_data_i[63:56];
    assign pci = ext_addr_enable_i ? rx_data_i[55:48] : rx_data_i[63:56]; // RULE_10

    cfa_frame_class u_class (
        .pci_i(pci),
        .is_first_o(is_first),
        .is_flow_o(is_flow),
        .is_single_o(is_single),
        .is_consec_o(is_consec)
    );

    function automatic logic near(input logic [WIN_W-1:0] v, input logic [15:0] ref_v);
        logic [WIN_W-1:0] lo;
        logic [WIN_W-1:0] hi;
        lo = (ref_v > EDGE_TOL) ? WIN_W'(ref_v - EDGE_TOL) : '0;
        hi = WIN_W'(ref_v + EDGE_TOL);
        return (v >= lo) && (v <= hi);
    endfunction

    // ------
    // Next state
    // ------
    always_comb begin
        logic want_fc;
        logic std_seen;
        want_fc = 1'b0;
        std_seen = 1'b0;
        st_d = st_q;
        st_d.err = 1'b0;
        st_d.ok = 1'b0;
        st_d.accept = 1'b0;

        if (flow_control_header_define_i) begin
            st_d.fc_id = flow_control_header_i; // RULE_06
            st_d.fc_ext = flow_control_header_ext_i;
            st_d.hdr_def = 1'b1;
        end
        if (flow_control_data_define_i) begin
            st_d.fc_data = flow_control_data_i;
            st_d.fc_len = (flow_control_data_len_i > 4'd8) ? 4'd8 : flow_control_data_len_i; // RULE_01
            st_d.dat_def = 1'b1;
        end
        if (transmit_extended_address_set_i) begin
            st_d.tx_ea = extended_address_i;
        end
        if (receive_extended_address_set_i) begin
            st_d.rx_ea = extended_address_i;
        end
        if (transmit_header_set_i) begin
            st_d.tx_hdr = transmit_header_i;
            st_d.tx_hdr_ext = transmit_header_ext_i;
        end
        if (frequency_match_parameter_set_i) begin
            st_d.fmatch = frequency_match_parameter_i; // RULE_16
        end

        // Defines in the same cycle count
        if (flow_control_mode_select_i) begin
            unique case (flow_control_mode_i)
                FC_MODE_AUTO, FC_MODE_AUTO_ALL: begin
                    st_d.mode = flow_control_mode_i; // RULE_08
                    st_d.ok = 1'b1;
                end
                FC_MODE_USER, FC_MODE_USER_ALL: begin
                    if (st_d.hdr_def && st_d.dat_def) begin
                        st_d.mode = flow_control_mode_i;
                        st_d.ok = 1'b1;
                    end else begin
                        st_d.err = 1'b1; // RULE_05
                    end
                end
                FC_MODE_DATA, FC_MODE_DATA_ALL: begin
                    if (st_d.dat_def) begin
                        st_d.mode = flow_control_mode_i;
                        st_d.ok = 1'b1;
                    end else begin
                        st_d.err = 1'b1;
                    end
                end
                default: st_d.err = 1'b1;
            endcase
        end

        // ------
        // Send gate during search
        // ------
        if (meas_done) begin
            std_seen = near(edges, EDGES_250) || near(edges, EDGES_500);
            if (edges <= WIN_W'(EDGES_SILENT)) begin
                st_d.allow = st_q.fmatch[FP_NOSIG_BIT]; // RULE_14
            end else if (!rate_is_standard_i) begin
                st_d.allow = !(std_seen && st_q.fmatch[FP_BLOCK_STD_BIT]); // RULE_15
            end else begin
                st_d.allow = !st_q.fmatch[FP_MATCH_BIT] || // RULE_14
                    (rate_is_500_i ? near(edges, EDGES_500) : near(edges, EDGES_250));
            end
        end
        if (!searching_i || bypass_initiation_i) begin
            st_d.allow = 1'b1; // RULE_17 RULE_18
        end

        // ------
        // Transmit slot
        // ------
        if (st_q.tx_valid && tx_ready_i) begin
            st_d.tx_valid = 1'b0;
        end
        st_d.host_rdy = !st_d.tx_valid && st_d.allow;

        if (rx_valid_i && (!ext_addr_enable_i || addr_byte == st_q.rx_ea)) begin // RULE_12
            st_d.accept = 1'b1;
            want_fc = flow_control_auto_enable_i && !is_flow && // RULE_03 RULE_20 RULE_13
                (st_q.mode[3] ? (is_first || is_single || is_consec) : is_first); // RULE_09
        end

        if (want_fc && !st_q.tx_valid) begin
            // Flow control preempts host traffic; the far sender is waiting
            st_d.tx_valid = 1'b1; // RULE_02
            unique case ({1'b0, st_q.mode[2:0]})
                FC_MODE_USER: begin
                    st_d.tx_id = st_q.fc_id; // RULE_06
                    st_d.tx_ext = st_q.fc_ext;
                    st_d.tx_data = st_q.fc_data;
                    st_d.tx_len = st_q.fc_len;
                end
                FC_MODE_DATA: begin
                    st_d.tx_id = rx_id_i; // RULE_07
                    st_d.tx_ext = rx_id_ext_i;
                    st_d.tx_data = st_q.fc_data;
                    st_d.tx_len = st_q.fc_len;
                end
                default: begin
                    st_d.tx_id = rx_id_ext_i ? rx_id_i : // RULE_04
                        (rx_id_i >= STD_ID_OFFSET) ? rx_id_i - STD_ID_OFFSET : STD_FC_ID;
                    st_d.tx_ext = rx_id_ext_i;
                    st_d.tx_data = STD_FC_DATA;
                    st_d.tx_len = 4'd8;
                    if (ext_addr_enable_i) begin
                        st_d.tx_data = {st_q.tx_ea, STD_FC_DATA[63:8]};
                    end
                end
            endcase
            st_d.host_rdy = 1'b0;
        end else if (host_valid_i && st_q.host_rdy) begin
            st_d.tx_valid = 1'b1;
            st_d.tx_id = st_q.tx_hdr; // RULE_11
            st_d.tx_ext = st_q.tx_hdr_ext;
            st_d.host_rdy = 1'b0;
            st_d.tx_len = 4'd8;
            if (ext_addr_enable_i) begin
                // Single frame only: address, length, up to six bytes
                st_d.tx_data = {st_q.tx_ea, 4'h0, host_len_i, host_data_i[55:8]}; // RULE_10 RULE_11
            end else begin
                st_d.tx_data = {4'h0, host_len_i, host_data_i}; // RULE_01
            end
        end
    end

    // ------
    // State register
    // ------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
            st_q.mode <= FC_MODE_AUTO; // RULE_04
            st_q.rx_ea <= RX_EXT_ADDR_RST; // RULE_12
            st_q.fmatch <= FREQ_MATCH_RST; // RULE_16
            st_q.allow <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign tx_valid_o = st_q.tx_valid;
    assign tx_id_o = st_q.tx_id;
    assign tx_id_ext_o = st_q.tx_ext;
    assign tx_data_o = st_q.tx_data;
    assign tx_len_o = st_q.tx_len;
    assign host_ready_o = st_q.host_rdy;
    assign mode_error_o = st_q.err;
    assign mode_ok_o = st_q.ok;
    assign flow_control_mode_o = st_q.mode;
    assign rx_accept_o = st_q.accept;
    assign send_allowed_o = st_q.allow;
    assign frequency_match_o = st_q.fmatch;
endmodule
`default_nettype wire

// >>> cfa_flow_ctrl_assertions.sv
// Checker of port-level timing for the flow control helper
`timescale 1ns/1ps
`default_nettype none
module cfa_flow_ctrl_chk
    import cfa_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic flow_control_auto_enable_i,
    input wire logic flow_control_mode_select_i,
    input wire logic [3:0] flow_control_mode_i,
    input wire logic flow_control_header_define_i,
    input wire logic ext_addr_enable_i,
    input wire logic frequency_match_parameter_set_i,
    input wire logic [7:0] frequency_match_parameter_i,
    input wire logic searching_i,
    input wire logic bypass_initiation_i,
    input wire logic rx_valid_i,
    input wire logic [28:0] rx_id_i,
    input wire logic rx_id_ext_i,
    input wire logic [63:0] rx_data_i,
    input wire logic host_valid_i,
    input wire logic tx_valid_o,
    input wire logic [28:0] tx_id_o,
    input wire logic [63:0] tx_data_o,
    input wire logic [3:0] tx_len_o,
    input wire logic mode_error_o,
    input wire logic mode_ok_o,
    input wire logic [3:0] flow_control_mode_o,
    input wire logic send_allowed_o,
    input wire logic [7:0] frequency_match_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic hdr_q;
    logic go;
    logic ff;
    // Reply owed only with a free slot and no address byte to match
    assign go = rx_valid_i && flow_control_auto_enable_i && !ext_addr_enable_i && !tx_valid_o;
    assign ff = go && rx_data_i[63:56] == PCI_FIRST;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hdr_q <= 1'b0;
        end else if (flow_control_header_define_i) begin
            hdr_q <= 1'b1;
        end
    end
    property p_len; tx_valid_o |-> tx_len_o <= 4'(DATA_BYTES); endproperty
    a_len: assert property (p_len) else $error("frame length over eight");
    property p_ff; ff |=> tx_valid_o; endproperty
    a_ff: assert property (p_ff) else $error("first frame not answered");
    property p_off; rx_valid_i && !flow_control_auto_enable_i && !tx_valid_o
        && !host_valid_i |=> !tx_valid_o; endproperty
    a_off: assert property (p_off) else $error("reply while auto off");
    property p_m0; ff && flow_control_mode_o == FC_MODE_AUTO && !rx_id_ext_i
        |=> tx_id_o == $past(rx_id_i) - STD_ID_OFFSET && tx_data_o == STD_FC_DATA; endproperty
    a_m0: assert property (p_m0) else $error("standard reply wrong");
    property p_m2; ff && flow_control_mode_o == FC_MODE_DATA |=> tx_id_o == $past(rx_id_i);
    endproperty
    a_m2: assert property (p_m2) else $error("reply id not copied");
    property p_m1; flow_control_mode_select_i && flow_control_mode_i == FC_MODE_USER && !hdr_q
        && !flow_control_header_define_i |=> mode_error_o && !mode_ok_o; endproperty
    a_m1: assert property (p_m1) else $error("user mode not refused");
    property p_rst; flow_control_mode_select_i && flow_control_mode_i == FC_MODE_AUTO
        |=> mode_ok_o && flow_control_mode_o == FC_MODE_AUTO; endproperty
    a_rst: assert property (p_rst) else $error("mode zero not restored");
    property p_all; go && flow_control_mode_o[3] && rx_data_i[63:60] == PCI_CONSEC_NIB
        |=> tx_valid_o; endproperty
    a_all: assert property (p_all) else $error("consecutive not answered");
    property p_fp; frequency_match_parameter_set_i
        |=> frequency_match_o == $past(frequency_match_parameter_i); endproperty
    a_fp: assert property (p_fp) else $error("match parameter not written");
    property p_byp; bypass_initiation_i [*8] |-> send_allowed_o; endproperty
    a_byp: assert property (p_byp) else $error("bypass still gated");
    property p_ns; !searching_i [*8] |-> send_allowed_o; endproperty
    a_ns: assert property (p_ns) else $error("gated outside search");
endmodule
bind cfa_flow_ctrl cfa_flow_ctrl_chk u_chk (.*);
`default_nettype wire

// >>> cfa_ecu_model.sv
// Far-side ECU model: transmit acceptance and CAN line activity
`timescale 1ns/1ps
`default_nettype none
module cfa_ecu_model (
    input wire logic clk_sys_i,
    input wire logic slow_i,
    input wire logic [7:0] half_i,
    output logic tx_ready_o,
    output logic can_rx_o
);
    int sd = 7;
    int cnt = 0;
    initial begin
        tx_ready_o = 1'b0;
        can_rx_o = 1'b1;
    end
    // Silent bus rests recessive; a slow node stalls at random
    always @(posedge clk_sys_i) begin
        tx_ready_o <= !slow_i || (($random(sd) & 1) == 1);
        cnt = cnt + 1;
        if (half_i == 8'h00) begin
            can_rx_o <= 1'b1;
        end else if (cnt >= int'(half_i)) begin
            cnt = 0;
            can_rx_o <= !can_rx_o;
        end
    end
endmodule
`default_nettype wire

// >>> test_cfa_flow_ctrl.sv
// Self-checking bench for the flow control helper
`timescale 1ns/1ps
`default_nettype none
module test_cfa_flow_ctrl;
    import cfa_pkg::*;
    logic clk_sys_i, resetn_i, flow_control_auto_enable_i, flow_control_mode_select_i;
    logic [3:0] flow_control_mode_i, flow_control_data_len_i, host_len_i, tx_len_o, m;
    logic [3:0] flow_control_mode_o;
    logic flow_control_header_define_i, flow_control_header_ext_i, flow_control_data_define_i;
    logic [28:0] flow_control_header_i, transmit_header_i, rx_id_i, tx_id_o, uh;
    logic [63:0] flow_control_data_i, rx_data_i, tx_data_o, ud, hp;
    logic transmit_extended_address_set_i, receive_extended_address_set_i, ext_addr_enable_i;
    logic [7:0] extended_address_i, frequency_match_parameter_i, frequency_match_o, half;
    logic transmit_header_set_i, transmit_header_ext_i, frequency_match_parameter_set_i;
    logic searching_i, rate_is_500_i, rate_is_standard_i, bypass_initiation_i, can_rx_i;
    logic rx_valid_i, rx_id_ext_i, host_valid_i, tx_ready_i, tx_valid_o, tx_id_ext_o, slow;
    logic [55:0] host_data_i;
    logic host_ready_o, mode_error_o, mode_ok_o, rx_accept_o, send_allowed_o;
    logic [93:0] got_q[$];
    int err_total, num_checks, seed, i, n_acc;
    cfa_flow_ctrl #(.RATE_WINDOW(16'd100), .EDGES_250(16'd10), .EDGES_500(16'd20),
        .EDGE_TOL(16'd3)) dut (.*);
    cfa_ecu_model ecu (.clk_sys_i(clk_sys_i), .slow_i(slow), .half_i(half),
        .tx_ready_o(tx_ready_i), .can_rx_o(can_rx_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (resetn_i && tx_valid_o && tx_ready_i) got_q.push_back({tx_id_ext_o, tx_id_o, tx_data_o});
        if (resetn_i && rx_accept_o) n_acc++;
    end
    // ------
    // Reference model and checks
    // ------
    function automatic logic [93:0] fc(logic [28:0] id);
        case (m[1:0])
            2'd1: fc = {1'b1, uh, ud};
            2'd2: fc = {1'b0, id, ud};
            default: fc = {1'b0, id - STD_ID_OFFSET, STD_FC_DATA};
        endcase
    endfunction
    task complete_run();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(string nm, logic [93:0] e, logic [93:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    task pop(logic [93:0] e, logic [93:0] k = '1);
        logic [93:0] g;
        g = got_q.size() > 0 ? got_q.pop_front() : 'x;
        chk("tx", e & k, g & k);
    endtask
    task tick(int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task rx(logic [28:0] id, logic [63:0] d);
        @(posedge clk_sys_i);
        rx_valid_i <= 1'b1;
        rx_id_i <= id;
        rx_data_i <= d;
        @(posedge clk_sys_i);
        rx_valid_i <= 1'b0;
        tick(24);
    endtask
    task sel(logic [3:0] v, logic [1:0] e);
        @(posedge clk_sys_i);
        flow_control_mode_select_i <= 1'b1;
        flow_control_mode_i <= v;
        @(posedge clk_sys_i);
        flow_control_mode_select_i <= 1'b0;
        #1;
        chk("ok_err", 94'(e), 94'({mode_ok_o, mode_error_o}));
        if (e == 2'b10) m = v;
        chk("mode", 94'(m), 94'(flow_control_mode_o));
    endtask
    task hs(logic [3:0] n, logic [55:0] d);
        for (i = 0; i < 60 && host_ready_o !== 1'b1; i++) tick(1);
        @(posedge clk_sys_i);
        host_valid_i <= 1'b1;
        host_len_i <= n;
        host_data_i <= d;
        @(posedge clk_sys_i);
        host_valid_i <= 1'b0;
        tick(24);
    endtask
    task gate(logic [2:0] c, logic [7:0] h, logic e);
        @(posedge clk_sys_i);
        {searching_i, bypass_initiation_i, rate_is_standard_i} <= c;
        half <= h;
        tick(350);
        chk("gate", 94'(e), 94'(send_allowed_o));
    endtask
    initial begin
        repeat (10000) @(posedge clk_sys_i);
        err_total++;
        complete_run();
    end
    initial begin
        seed = 32'h258d;
        {resetn_i, flow_control_mode_select_i, flow_control_mode_i, flow_control_header_define_i,
            flow_control_header_i, flow_control_header_ext_i, flow_control_data_define_i} = '0;
        {flow_control_data_i, flow_control_data_len_i, transmit_extended_address_set_i} = '0;
        {receive_extended_address_set_i, extended_address_i, ext_addr_enable_i, searching_i} = '0;
        {transmit_header_set_i, transmit_header_i, transmit_header_ext_i, rate_is_500_i} = '0;
        {frequency_match_parameter_set_i, frequency_match_parameter_i, bypass_initiation_i} = '0;
        {rx_valid_i, rx_id_i, rx_id_ext_i, rx_data_i, host_valid_i, host_data_i} = '0;
        {host_len_i, half, slow} = '0;
        flow_control_auto_enable_i = 1'b1;
        rate_is_standard_i = 1'b1;
        m = FC_MODE_AUTO;
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        tick(2);
        chk("rst", 94'({4'h0, 1'b1, FREQ_MATCH_RST}),
            94'({flow_control_mode_o, send_allowed_o, frequency_match_o}));
        rx(29'h7e8, {PCI_FIRST, 8'h14, 48'h0});
        pop(fc(29'h7e8));
        rx(29'h7e8, {8'h02, 8'h01, 48'h0});
        chk("single", 0, 94'(got_q.size()));
        sel(FC_MODE_USER, 2'b01);
        uh = 29'h18da10f1;
        ud = {24'($random(seed)), 40'h0};
        @(posedge clk_sys_i);
        flow_control_header_define_i <= 1'b1;
        flow_control_header_i <= uh;
        flow_control_header_ext_i <= 1'b1;
        @(posedge clk_sys_i);
        flow_control_header_define_i <= 1'b0;
        sel(FC_MODE_USER, 2'b01);
        @(posedge clk_sys_i);
        flow_control_data_define_i <= 1'b1;
        flow_control_data_i <= ud;
        flow_control_data_len_i <= 4'd3;
        @(posedge clk_sys_i);
        flow_control_data_define_i <= 1'b0;
        sel(FC_MODE_USER, 2'b10);
        slow <= 1'b1;
        rx(29'h7e8, {PCI_FIRST, 8'h20, 48'h0});
        pop(fc(29'h7e8));
        sel(FC_MODE_DATA, 2'b10);
        rx(29'h7e9, {PCI_FIRST, 8'h20, 48'h0});
        pop(fc(29'h7e9));
        sel(FC_MODE_AUTO, 2'b10);
        rx(29'h7ea, {PCI_FIRST, 8'h20, 48'h0});
        pop(fc(29'h7ea));
        @(posedge clk_sys_i);
        flow_control_auto_enable_i <= 1'b0;
        rx(29'h7e8, {PCI_FIRST, 8'h20, 48'h0});
        chk("auto_off", 0, 94'(got_q.size()));
        flow_control_auto_enable_i <= 1'b1;
        for (int k = 8; k < 11; k++) begin
            sel(4'(k), 2'b10);
            rx(29'h7e8, {PCI_FIRST, 8'h30, 48'h0});
            pop(fc(29'h7e8));
            rx(29'h7e8, {8'h21, 56'h0});
            pop(fc(29'h7e8));
            rx(29'h7e8, {PCI_FLOW, 56'h0});
            chk("flow", 0, 94'(got_q.size()));
        end
        sel(4'h5, 2'b01);
        sel(FC_MODE_AUTO, 2'b10);
        $display("test flow modes done");
        hp = {$random(seed), $random(seed)};
        @(posedge clk_sys_i);
        transmit_header_set_i <= 1'b1;
        transmit_header_i <= 29'h7df;
        @(posedge clk_sys_i);
        transmit_header_set_i <= 1'b0;
        hs(4'd7, hp[55:0]);
        pop({1'b0, 29'h7df, 8'h07, hp[55:0]});
        @(posedge clk_sys_i);
        transmit_header_set_i <= 1'b1;
        transmit_header_i <= 29'h7b0;
        transmit_extended_address_set_i <= 1'b1;
        extended_address_i <= 8'h04;
        ext_addr_enable_i <= 1'b1;
        @(posedge clk_sys_i);
        {transmit_header_set_i, transmit_extended_address_set_i} <= 2'b00;
        hs(4'd2, {16'h1081, 40'h0});
        pop({1'b0, 29'h7b0, 32'h04021081, 32'h0}, {{62{1'b1}}, 32'h0});
        rx(29'h7e8, {8'hf1, PCI_FIRST, 8'h14, 40'h0});
        pop({1'b0, 29'h7e0, 8'h04, PCI_FLOW, 48'h0});
        rx(29'h7e8, {8'h04, PCI_FIRST, 8'h14, 40'h0});
        chk("ext_addr", 0, 94'(got_q.size()));
        ext_addr_enable_i <= 1'b0;
        $display("test addressing done");
        gate(3'b101, 8'd0, 1'b1);
        gate(3'b101, 8'd10, 1'b1);
        gate(3'b101, 8'd2, 1'b0);
        rate_is_500_i <= 1'b1;
        gate(3'b101, 8'd5, 1'b1);
        gate(3'b101, 8'd10, 1'b0);
        rate_is_500_i <= 1'b0;
        gate(3'b100, 8'd10, 1'b0);
        gate(3'b111, 8'd2, 1'b1);
        gate(3'b001, 8'd2, 1'b1);
        @(posedge clk_sys_i);
        frequency_match_parameter_set_i <= 1'b1;
        frequency_match_parameter_i <= 8'h00;
        @(posedge clk_sys_i);
        frequency_match_parameter_set_i <= 1'b0;
        tick(1);
        chk("fmatch", 0, 94'(frequency_match_o));
        gate(3'b101, 8'd2, 1'b1);
        chk("accept", 16, 94'(n_acc));
        $display("test send gate done");
        complete_run();
    end
endmodule
`default_nettype wire
